// File: design/io_register_space_decoder.sv
// Low I/O register space of the microcontroller: decode, storage and read-back.
// Assumes the core clock and reset; peripherals raise flag events as one-cycle pulses.
// Function
// - Registers at I/O 0x00..0x1f accept single-bit set and clear operations.
// - Bit-accessible registers let the core test one bit for a skip decision.
// - Status flags clear on writing one, and writing zero leaves them alone; reset cause flags at 0x34 clear on writing zero.
// - A bit set or clear touches only the addressed bit, sparing other flags.
// - Bit set and clear act only on I/O 0x00..0x1f, never higher.
// - Short I/O reads and writes use I/O addresses 0x00..0x3f.
// - Data-space access reaches each register at its I/O address plus 0x20.
// - The short I/O opcode field reaches 64 locations and no more.
// - Extended registers at data 0x60..0xff are reached only by data-space access.
// - Port D latch sits at 0x0b with eight bits, direction at 0x0a, sense at 0x09.
// - Port C latch at 0x08 holds bits 6..0 only; bit 7 is reserved.
`timescale 1ns/1ps
`default_nettype none
module io_register_space_decoder (
	// Clock and reset
	input  wire logic                       I_MCLK,
	input  wire logic                       I_RSTN,
	// Core access
	input  wire io_space_pkg::core_access_t I_ACC,
	output logic      [7:0]                 O_RDATA,
	output logic                            O_BIT_TRUE,
	output logic                            O_EXT_SEL,
	// Port pins
	input  wire logic [7:0]                 I_PORT_B_PINS,
	input  wire logic [7:0]                 I_PORT_C_PINS,
	input  wire logic [7:0]                 I_PORT_D_PINS,
	output logic      [7:0]                 O_PORT_B_OUT,
	output logic      [7:0]                 O_PORT_B_OE,
	output logic      [7:0]                 O_PORT_C_OUT,
	output logic      [7:0]                 O_PORT_C_OE,
	output logic      [7:0]                 O_PORT_D_OUT,
	output logic      [7:0]                 O_PORT_D_OE,
	// Flag events from peripherals
	input  wire logic [7:0]                 I_TIMER0_EVT,
	input  wire logic [7:0]                 I_TIMER1_EVT,
	input  wire logic [7:0]                 I_TIMER2_EVT,
	input  wire logic [7:0]                 I_PIN_CHANGE_EVT,
	input  wire logic [7:0]                 I_EXT_IRQ_EVT,
	input  wire logic [7:0]                 I_SPI_STATUS_EVT,
	input  wire logic [7:0]                 I_COMPARATOR_EVT,
	input  wire logic [7:0]                 I_RESET_CAUSE_EVT,
	// Plain control registers to peripherals
	output logic      [7:0]                 O_EXT_IRQ_MASK,
	output logic      [7:0]                 O_NVM_CONTROL,
	output logic      [7:0]                 O_NVM_DATA,
	output logic      [15:0]                O_NVM_ADDR,
	output logic      [7:0]                 O_TIMER_PRESCALER,
	output logic      [7:0]                 O_TIMER0_CONTROL_A,
	output logic      [7:0]                 O_TIMER0_CONTROL_B,
	output logic      [7:0]                 O_TIMER0_COUNT,
	output logic      [7:0]                 O_TIMER0_COMPARE_A,
	output logic      [7:0]                 O_TIMER0_COMPARE_B,
	output logic      [7:0]                 O_SPI_CONTROL,
	output logic      [7:0]                 O_SPI_DATA,
	output logic      [7:0]                 O_SLEEP_CONTROL
);

	// ****************************************************************
	// Register table
	// ****************************************************************
	localparam int NREG = 32;

	typedef enum logic [1:0] {
		KIND_RW  = 2'h0,
		KIND_RO  = 2'h1,
		KIND_W1C = 2'h2,
		KIND_NONE = 2'h3
	} reg_kind_t;

	// Per slot: address, implemented bits, kind
	localparam logic [5:0] SLOT_ADDR [NREG] = '{
		io_space_pkg::PORT_B_INPUT_SENSE, io_space_pkg::PORT_B_DIRECTION,
		io_space_pkg::PORT_B_OUTPUT_LATCH, io_space_pkg::PORT_C_INPUT_SENSE,
		io_space_pkg::PORT_C_DIRECTION, io_space_pkg::PORT_C_OUTPUT_LATCH,
		io_space_pkg::PORT_D_INPUT_SENSE, io_space_pkg::PORT_D_DIRECTION,
		io_space_pkg::PORT_D_OUTPUT_LATCH, io_space_pkg::TIMER0_FLAGS,
		io_space_pkg::TIMER1_FLAGS, io_space_pkg::TIMER2_FLAGS,
		io_space_pkg::PIN_CHANGE_FLAGS, io_space_pkg::EXT_IRQ_FLAGS,
		io_space_pkg::EXT_IRQ_MASK, io_space_pkg::GENERAL_SCRATCH_0,
		io_space_pkg::NVM_CONTROL, io_space_pkg::NVM_DATA,
		io_space_pkg::NVM_ADDR_LOW, io_space_pkg::NVM_ADDR_HIGH,
		io_space_pkg::TIMER_PRESCALER_CTRL, io_space_pkg::TIMER0_CONTROL_A,
		io_space_pkg::TIMER0_CONTROL_B, io_space_pkg::TIMER0_COUNT,
		io_space_pkg::TIMER0_COMPARE_A, io_space_pkg::TIMER0_COMPARE_B,
		io_space_pkg::GENERAL_SCRATCH_1, io_space_pkg::GENERAL_SCRATCH_2,
		io_space_pkg::SERIAL_PERIPH_CONTROL, io_space_pkg::SERIAL_PERIPH_STATUS,
		io_space_pkg::SERIAL_PERIPH_DATA, io_space_pkg::COMPARATOR_CTRL_STATUS
	};
	localparam logic [7:0] SLOT_MASK [NREG] = '{
		io_space_pkg::MASK_ALL, io_space_pkg::MASK_ALL, io_space_pkg::MASK_ALL,
		io_space_pkg::MASK_PORT_C, io_space_pkg::MASK_PORT_C, io_space_pkg::MASK_PORT_C,
		io_space_pkg::MASK_ALL, io_space_pkg::MASK_ALL, io_space_pkg::MASK_ALL,
		io_space_pkg::MASK_TIMER_FLAGS, io_space_pkg::MASK_TIMER1_FLAGS,
		io_space_pkg::MASK_TIMER_FLAGS, io_space_pkg::MASK_LOW3,
		io_space_pkg::MASK_LOW2, io_space_pkg::MASK_LOW2, io_space_pkg::MASK_ALL,
		io_space_pkg::MASK_NVM_CONTROL, io_space_pkg::MASK_ALL, io_space_pkg::MASK_ALL,
		io_space_pkg::MASK_NVM_ADDR_HI, io_space_pkg::MASK_PRESCALER,
		io_space_pkg::MASK_TIMER0_A, io_space_pkg::MASK_TIMER0_B,
		io_space_pkg::MASK_ALL, io_space_pkg::MASK_ALL, io_space_pkg::MASK_ALL,
		io_space_pkg::MASK_ALL, io_space_pkg::MASK_ALL, io_space_pkg::MASK_ALL,
		io_space_pkg::MASK_SPI_STATUS, io_space_pkg::MASK_ALL,
		io_space_pkg::MASK_COMPARATOR
	};
	localparam reg_kind_t SLOT_KIND [NREG] = '{
		KIND_RO, KIND_RW, KIND_RW, KIND_RO, KIND_RW, KIND_RW, KIND_RO, KIND_RW,
		KIND_RW, KIND_W1C, KIND_W1C, KIND_W1C, KIND_W1C, KIND_W1C, KIND_RW,
		KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_RW,
		KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_W1C, KIND_RW,
		KIND_RW
	};

	// ****************************************************************
	// Decode and pin sampling
	// ****************************************************************
	io_space_pkg::io_access_t io;
	logic [23:0]              pins_sync;
	logic [7:0]               regs [NREG];
	logic [7:0]               reset_cause;
	logic [7:0]               slot_evt [NREG];
	logic [7:0]               rd_mux;

	io_access_decoder u_decode (
		.i_acc (I_ACC),
		.o_io  (io)
	);

	io_pin_sync u_sync (
		.i_clk  (I_MCLK),
		.i_rstn (I_RSTN),
		.i_pins ({I_PORT_D_PINS, I_PORT_C_PINS, I_PORT_B_PINS}),
		.o_pins (pins_sync)
	);

	always_comb begin
		for (int k = 0; k < NREG; k++) begin
			slot_evt[k] = '0;
		end
		slot_evt[9]  = I_TIMER0_EVT;
		slot_evt[10] = I_TIMER1_EVT;
		slot_evt[11] = I_TIMER2_EVT;
		slot_evt[12] = I_PIN_CHANGE_EVT;
		slot_evt[13] = I_EXT_IRQ_EVT;
		slot_evt[29] = I_SPI_STATUS_EVT;
		slot_evt[31] = I_COMPARATOR_EVT;
	end

	// ****************************************************************
	// Register storage, one slot per generate entry
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < NREG; g++) begin : gen_slot
			logic       hit;
			logic [7:0] wr_val;
			logic [7:0] w1c_bits;
			logic [7:0] next_val;
			assign hit = io.wr && io.io_addr == SLOT_ADDR[g];
			always_comb begin
				wr_val   = regs[g];
				w1c_bits = '0;
				if (io.bit_op) begin
					// Only the selected bit moves; flags elsewhere untouched
					if (I_ACC.kind == io_space_pkg::ACC_SETBIT) begin
						wr_val   = regs[g] | io.bit_mask;
						w1c_bits = io.bit_mask;
					end else begin
						wr_val = regs[g] & ~io.bit_mask;
					end
				end else begin
					wr_val   = io.wdata;
					w1c_bits = io.wdata;
				end
				next_val = regs[g];
				if (SLOT_KIND[g] == KIND_W1C) begin
					if (hit) begin
						next_val = regs[g] & ~w1c_bits;
					end
					if (g == 29 && hit) begin
						next_val = (next_val & io_space_pkg::RO_SPI_STATUS)
						         | (wr_val & ~io_space_pkg::RO_SPI_STATUS);
					end
					// Event wins over a same-cycle clear
					next_val = next_val | slot_evt[g];
				end else if (SLOT_KIND[g] == KIND_RW) begin
					if (hit) begin
						next_val = wr_val;
					end
					if (g == 31) begin
						if (hit) begin
							next_val = (wr_val & ~io_space_pkg::W1C_COMPARATOR)
							         | (regs[g] & ~w1c_bits
							            & io_space_pkg::W1C_COMPARATOR);
						end
						next_val = next_val | (slot_evt[g] & io_space_pkg::W1C_COMPARATOR);
					end
				end else begin
					// Modulo keeps the slice in range for slots that never take this branch
					next_val = pins_sync[((g/3)%3)*8 +: 8];
				end
				next_val = next_val & SLOT_MASK[g];
			end
			always_ff @(posedge I_MCLK or negedge I_RSTN) begin
				if (!I_RSTN) begin
					regs[g] <= io_space_pkg::RESET_VALUE;
				end else begin
					regs[g] <= next_val;
				end
			end
		end
	endgenerate

	// Reset cause: sticky, cleared by writing zero to a bit (not a bit-op range)
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			reset_cause <= io_space_pkg::RESET_VALUE;
		end else if (io.wr && io.io_addr == io_space_pkg::RESET_CAUSE_FLAGS) begin
			reset_cause <= ((reset_cause & io.wdata) | I_RESET_CAUSE_EVT)
			             & io_space_pkg::MASK_RESET_CAUSE;
		end else begin
			reset_cause <= (reset_cause | I_RESET_CAUSE_EVT) & io_space_pkg::MASK_RESET_CAUSE;
		end
	end

	// Sleep control lives outside the table: it sits past the bit-op range
	logic [7:0] sleep_ctrl;
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			sleep_ctrl <= io_space_pkg::RESET_VALUE;
		end else if (io.wr && io.io_addr == io_space_pkg::SLEEP_CONTROL) begin
			sleep_ctrl <= io.wdata & io_space_pkg::MASK_SLEEP;
		end
	end

	// ****************************************************************
	// Read-back and bit test
	// ****************************************************************
	always_comb begin
		rd_mux = '0;
		for (int k = 0; k < NREG; k++) begin
			if (io.io_addr == SLOT_ADDR[k]) begin
				rd_mux = regs[k];
			end
		end
		if (io.io_addr == io_space_pkg::RESET_CAUSE_FLAGS) begin
			rd_mux = reset_cause;
		end
		if (io.io_addr == io_space_pkg::SLEEP_CONTROL) begin
			rd_mux = sleep_ctrl;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_RDATA    <= '0;
			O_BIT_TRUE <= 1'b0;
			O_EXT_SEL  <= 1'b0;
		end else begin
			O_RDATA    <= (io.rd && !io.bit_op) ? rd_mux : 8'h00;
			// High when the tested bit is one; core skips on set or clear
			O_BIT_TRUE <= io.rd && io.bit_op && |(rd_mux & io.bit_mask);
			O_EXT_SEL  <= io.ext;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign O_PORT_B_OE        = regs[1];
	assign O_PORT_B_OUT       = regs[2];
	assign O_PORT_C_OE        = regs[4];
	assign O_PORT_C_OUT       = regs[5];
	assign O_PORT_D_OE        = regs[7];
	assign O_PORT_D_OUT       = regs[8];
	assign O_EXT_IRQ_MASK     = regs[14];
	assign O_NVM_CONTROL      = regs[16];
	assign O_NVM_DATA         = regs[17];
	assign O_NVM_ADDR         = {regs[19], regs[18]};
	assign O_TIMER_PRESCALER  = regs[20];
	assign O_TIMER0_CONTROL_A = regs[21];
	assign O_TIMER0_CONTROL_B = regs[22];
	assign O_TIMER0_COUNT     = regs[23];
	assign O_TIMER0_COMPARE_A = regs[24];
	assign O_TIMER0_COMPARE_B = regs[25];
	assign O_SPI_CONTROL      = regs[28];
	assign O_SPI_DATA         = regs[30];
	assign O_SLEEP_CONTROL    = sleep_ctrl;

endmodule
`default_nettype wire

// File: design/io_space_pkg.sv
// Package for the low I/O register space decoder: offsets, field masks, access kinds.
// Assumes an 8-bit core data path and I/O addresses 0x00..0x3f.
package io_space_pkg;

	// ****************************************************************
	// Address space
	// ****************************************************************
	localparam logic [5:0] BIT_OP_LAST      = 6'h1f;
	localparam logic [7:0] DATA_IO_OFFSET   = 8'h20;
	localparam logic [7:0] DATA_IO_LAST     = 8'h5f;
	localparam logic [7:0] DATA_EXT_FIRST   = 8'h60;
	localparam int         IO_LOCATIONS     = 64;

	// ****************************************************************
	// Register offsets (I/O addresses)
	// ****************************************************************
	localparam logic [5:0] PORT_B_INPUT_SENSE     = 6'h03;
	localparam logic [5:0] PORT_B_DIRECTION       = 6'h04;
	localparam logic [5:0] PORT_B_OUTPUT_LATCH    = 6'h05;
	localparam logic [5:0] PORT_C_INPUT_SENSE     = 6'h06;
	localparam logic [5:0] PORT_C_DIRECTION       = 6'h07;
	localparam logic [5:0] PORT_C_OUTPUT_LATCH    = 6'h08;
	localparam logic [5:0] PORT_D_INPUT_SENSE     = 6'h09;
	localparam logic [5:0] PORT_D_DIRECTION       = 6'h0a;
	localparam logic [5:0] PORT_D_OUTPUT_LATCH    = 6'h0b;
	localparam logic [5:0] TIMER0_FLAGS           = 6'h15;
	localparam logic [5:0] TIMER1_FLAGS           = 6'h16;
	localparam logic [5:0] TIMER2_FLAGS           = 6'h17;
	localparam logic [5:0] PIN_CHANGE_FLAGS       = 6'h1b;
	localparam logic [5:0] EXT_IRQ_FLAGS          = 6'h1c;
	localparam logic [5:0] EXT_IRQ_MASK           = 6'h1d;
	localparam logic [5:0] GENERAL_SCRATCH_0      = 6'h1e;
	localparam logic [5:0] NVM_CONTROL            = 6'h1f;
	localparam logic [5:0] NVM_DATA               = 6'h20;
	localparam logic [5:0] NVM_ADDR_LOW           = 6'h21;
	localparam logic [5:0] NVM_ADDR_HIGH          = 6'h22;
	localparam logic [5:0] TIMER_PRESCALER_CTRL   = 6'h23;
	localparam logic [5:0] TIMER0_CONTROL_A       = 6'h24;
	localparam logic [5:0] TIMER0_CONTROL_B       = 6'h25;
	localparam logic [5:0] TIMER0_COUNT           = 6'h26;
	localparam logic [5:0] TIMER0_COMPARE_A       = 6'h27;
	localparam logic [5:0] TIMER0_COMPARE_B       = 6'h28;
	localparam logic [5:0] GENERAL_SCRATCH_1      = 6'h2a;
	localparam logic [5:0] GENERAL_SCRATCH_2      = 6'h2b;
	localparam logic [5:0] SERIAL_PERIPH_CONTROL  = 6'h2c;
	localparam logic [5:0] SERIAL_PERIPH_STATUS   = 6'h2d;
	localparam logic [5:0] SERIAL_PERIPH_DATA     = 6'h2e;
	localparam logic [5:0] COMPARATOR_CTRL_STATUS = 6'h30;
	localparam logic [5:0] SLEEP_CONTROL          = 6'h33;
	localparam logic [5:0] RESET_CAUSE_FLAGS      = 6'h34;

	// ****************************************************************
	// Field masks: implemented bits and write-one-to-clear bits
	// ****************************************************************
	localparam logic [7:0] MASK_ALL          = 8'hff;
	localparam logic [7:0] MASK_PORT_C       = 8'h7f;
	localparam logic [7:0] MASK_TIMER_FLAGS  = 8'h07;
	localparam logic [7:0] MASK_TIMER1_FLAGS = 8'h27;
	localparam logic [7:0] MASK_LOW3         = 8'h07;
	localparam logic [7:0] MASK_LOW2         = 8'h03;
	localparam logic [7:0] MASK_NVM_CONTROL  = 8'h3f;
	localparam logic [7:0] MASK_NVM_ADDR_HI  = 8'h01;
	localparam logic [7:0] MASK_PRESCALER    = 8'h83;
	localparam logic [7:0] MASK_TIMER0_A     = 8'hf3;
	localparam logic [7:0] MASK_TIMER0_B     = 8'hcf;
	localparam logic [7:0] MASK_SPI_STATUS   = 8'hc1;
	localparam logic [7:0] MASK_SLEEP        = 8'h0f;
	localparam logic [7:0] MASK_RESET_CAUSE  = 8'h0f;
	localparam logic [7:0] MASK_COMPARATOR   = 8'hdf;
	localparam logic [7:0] W1C_COMPARATOR    = 8'h10;
	localparam logic [7:0] RO_SPI_STATUS     = 8'hc0;
	localparam logic [7:0] RESET_VALUE       = 8'h00;

	// ****************************************************************
	// Access kinds and carriers
	// ****************************************************************
	typedef enum logic [5:0] {
		ACC_IDLE   = 6'b000001,
		ACC_READ   = 6'b000010,
		ACC_WRITE  = 6'b000100,
		ACC_SETBIT = 6'b001000,
		ACC_CLRBIT = 6'b010000,
		ACC_TEST   = 6'b100000
	} access_kind_t;

	// One core access: kind, which path, address, data, bit select
	typedef struct packed {
		access_kind_t kind;
		logic         data_space;
		logic [7:0]   addr;
		logic [7:0]   wdata;
		logic [2:0]   bit_sel;
	} core_access_t;

	// One decoded register access on the I/O address space
	typedef struct packed {
		logic       valid;
		logic       rd;
		logic       wr;
		logic       bit_op;
		logic [5:0] io_addr;
		logic [7:0] bit_mask;
		logic [7:0] wdata;
		logic       ext;
	} io_access_t;

endpackage

// File: design/io_access_decoder.sv
// Address decoder: turns a core access into an I/O space access.
// Assumes the core presents one access per cycle, from the same clock.
`timescale 1ns/1ps
`default_nettype none
module io_access_decoder (
	// Core access
	input  wire io_space_pkg::core_access_t i_acc,
	// Decoded access
	output io_space_pkg::io_access_t        o_io
);
	logic [7:0] io_addr8;
	logic       in_io;
	logic       bit_ok;

	always_comb begin
		o_io = '0;
		// Data path sees register at I/O address plus offset
		io_addr8 = i_acc.data_space ? (i_acc.addr - io_space_pkg::DATA_IO_OFFSET)
		                            : i_acc.addr;
		// Short I/O opcodes carry a 6-bit field: only 64 locations reachable
		in_io = i_acc.data_space
		      ? (i_acc.addr >= io_space_pkg::DATA_IO_OFFSET
		         && i_acc.addr <= io_space_pkg::DATA_IO_LAST)
		      : (i_acc.addr[7:6] == 2'b00);
		bit_ok = !i_acc.data_space && in_io
		      && io_addr8[5:0] <= io_space_pkg::BIT_OP_LAST;
		o_io.io_addr  = io_addr8[5:0];
		o_io.wdata    = i_acc.wdata;
		o_io.bit_mask = 8'h01 << i_acc.bit_sel;
		// Extended space only through data-space loads and stores; idle is no access
		o_io.ext = i_acc.data_space
		         && (i_acc.kind == io_space_pkg::ACC_READ
		             || i_acc.kind == io_space_pkg::ACC_WRITE)
		         && i_acc.addr >= io_space_pkg::DATA_EXT_FIRST;
		unique case (i_acc.kind)
			io_space_pkg::ACC_IDLE: begin
			end
			io_space_pkg::ACC_READ: begin
				o_io.valid = in_io;
				o_io.rd    = in_io;
			end
			io_space_pkg::ACC_WRITE: begin
				o_io.valid = in_io;
				o_io.wr    = in_io;
			end
			io_space_pkg::ACC_SETBIT, io_space_pkg::ACC_CLRBIT: begin
				o_io.valid  = bit_ok;
				o_io.wr     = bit_ok;
				o_io.bit_op = bit_ok;
			end
			io_space_pkg::ACC_TEST: begin
				o_io.valid  = bit_ok;
				o_io.rd     = bit_ok;
				o_io.bit_op = bit_ok;
			end
			default: begin
			end
		endcase
	end
endmodule
`default_nettype wire

// File: design/io_pin_sync.sv
// Two-flop synchroniser for the three port input buses.
// Assumes pins are asynchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module io_pin_sync (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	// Pins
	input  wire logic [23:0] i_pins,
	// Synchronised
	output logic      [23:0] o_pins
);
	logic [23:0] meta;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta   <= '0;
			o_pins <= '0;
		end else begin
			meta   <= i_pins;
			o_pins <= meta;
		end
	end
endmodule
`default_nettype wire

// File: dv/core_access_model.sv
// Model of the processor core that issues accesses to the I/O space.
// Assumes the decoder takes one access on each rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module core_access_model (
	// Clock
	input  wire logic                  i_clk,
	// Access and answers
	output var io_space_pkg::core_access_t o_acc,
	input  wire logic [7:0]            i_rdata,
	input  wire logic                  i_bit_true
);
	// ********
	// Access driver
	// ********
	// Set only by a scenario that writes reserved bits on purpose
	bit lax = 1'b0;
	initial
		o_acc = '{io_space_pkg::ACC_IDLE, 1'b0, 8'h00, 8'h00, 3'h0};
	task automatic access(input io_space_pkg::access_kind_t k, input logic ds,
		input logic [7:0] a, input logic [7:0] d, input logic [2:0] b,
		output logic [7:0] rd, output logic bt);
		logic [7:0] w;
		w = d;
		if (!lax && !ds && a == 8'h08)
			w = d & 8'h7f;
		rd = 8'h00;
		bt = 1'b0;
		if (k == io_space_pkg::ACC_WRITE && !ds && a inside {[8'h0c:8'h14]})
			return;
		@(negedge i_clk);
		o_acc <= '{k, ds, a, w, b};
		@(posedge i_clk);
		@(negedge i_clk);
		rd = i_rdata;
		bt = i_bit_true;
		// Idle fields are scrambled so stale values cannot pass for data
		o_acc <= '{io_space_pkg::ACC_IDLE, 1'b0, ~a, ~w, ~b};
	endtask
endmodule
`default_nettype wire

// File: dv/io_space_checker.sv
// Assertions on the low I/O register space decoder ports.
// Assumes one core clock and the asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module io_space_checker (
	// Clock and reset
	input wire logic                       I_MCLK,
	input wire logic                       I_RSTN,
	// Core side
	input wire io_space_pkg::core_access_t I_ACC,
	input wire logic [7:0]                 O_RDATA,
	input wire logic                       O_BIT_TRUE,
	input wire logic                       O_EXT_SEL,
	// Register contents
	input wire logic [7:0]                 O_PORT_C_OUT,
	input wire logic [7:0]                 O_PORT_D_OUT,
	input wire logic [7:0]                 O_SPI_CONTROL
);
	// ********
	// Access views
	// ********
	wire logic io = !I_ACC.data_space;
	wire logic setb = I_ACC.kind == io_space_pkg::ACC_SETBIT;
	wire logic clrb = I_ACC.kind == io_space_pkg::ACC_CLRBIT;
	wire logic rd = I_ACC.kind == io_space_pkg::ACC_READ;
	wire logic pd = io && I_ACC.addr == 8'h0b;
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RSTN);
	property p_set;
		setb && pd |=> O_PORT_D_OUT == ($past(O_PORT_D_OUT) | (8'h01 << $past(I_ACC.bit_sel)));
	endproperty
	a_set: assert property (p_set) else $error("bit set changed other bits");
	property p_clr;
		clrb && pd |=> O_PORT_D_OUT == ($past(O_PORT_D_OUT) & ~(8'h01 << $past(I_ACC.bit_sel)));
	endproperty
	a_clr: assert property (p_clr) else $error("bit clear changed other bits");
	property p_high;
		(setb || clrb) && I_ACC.addr > 8'h1f |=> $stable(O_SPI_CONTROL);
	endproperty
	a_high: assert property (p_high) else $error("bit op acted above 0x1f");
	property p_test;
		I_ACC.kind == io_space_pkg::ACC_TEST && pd
			|=> O_BIT_TRUE == 1'($past(O_PORT_D_OUT) >> $past(I_ACC.bit_sel));
	endproperty
	a_test: assert property (p_test) else $error("bit test result wrong");
	property p_ds;
		I_ACC.kind == io_space_pkg::ACC_WRITE && !io && I_ACC.addr == 8'h2b
			|=> O_PORT_D_OUT == $past(I_ACC.wdata);
	endproperty
	a_ds: assert property (p_ds) else $error("data space write missed");
	property p_pc;
		rd && io && I_ACC.addr == 8'h08 |=> !O_RDATA[7] && !O_PORT_C_OUT[7];
	endproperty
	a_pc: assert property (p_pc) else $error("port c bit 7 set");
	property p_far;
		rd && io && I_ACC.addr > 8'h3f |=> O_RDATA == 8'h00;
	endproperty
	a_far: assert property (p_far) else $error("short read beyond 0x3f");
	property p_ext;
		rd && !io && I_ACC.addr >= 8'h60 |=> O_EXT_SEL;
	endproperty
	a_ext: assert property (p_ext) else $error("extended select wrong");
	// Back-to-back extended reads are legal, so the drop is tied to an idle cycle
	property p_noext;
		I_ACC.kind == io_space_pkg::ACC_IDLE |=> !O_EXT_SEL;
	endproperty
	a_noext: assert property (p_noext) else $error("stray extended select");
	property p_resv;
		rd && io && I_ACC.addr inside {[8'h0c:8'h14]} |=> O_RDATA == 8'h00;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved read not zero");
	c_set: cover property (setb && pd);
	c_test: cover property (I_ACC.kind == io_space_pkg::ACC_TEST && pd);
	c_ext: cover property (rd && !io && I_ACC.addr >= 8'h60);
endmodule
bind io_register_space_decoder io_space_checker i_io_space_checker (
	.I_MCLK(I_MCLK), .I_RSTN(I_RSTN), .I_ACC(I_ACC), .O_RDATA(O_RDATA),
	.O_BIT_TRUE(O_BIT_TRUE), .O_EXT_SEL(O_EXT_SEL), .O_PORT_C_OUT(O_PORT_C_OUT),
	.O_PORT_D_OUT(O_PORT_D_OUT), .O_SPI_CONTROL(O_SPI_CONTROL)
);
`default_nettype wire

// File: dv/io_register_space_decoder_tb.sv
// Testbench for the low I/O register space decoder.
// Assumes the core model in core_access_model.sv drives all accesses.
`timescale 1ns/1ps
`default_nettype none
module io_register_space_decoder_tb;
	logic mclk, rstn, bit_q, bit_true, ext_sel;
	logic [7:0] rdata_q, rdata, pins, evt, port_c_out, port_d_oe;
	io_space_pkg::core_access_t acc;
	int errors = 0;
	int n_checks = 0;
	int cycles = 0;
	io_register_space_decoder i_io_register_space_decoder (
		.I_MCLK(mclk), .I_RSTN(rstn), .I_ACC(acc), .O_RDATA(rdata_q),
		.O_BIT_TRUE(bit_q), .O_EXT_SEL(ext_sel), .I_PORT_B_PINS(pins),
		.I_PORT_C_PINS(pins), .I_PORT_D_PINS(pins), .O_PORT_B_OUT(), .O_PORT_B_OE(),
		.O_PORT_C_OUT(port_c_out), .O_PORT_C_OE(), .O_PORT_D_OUT(), .O_PORT_D_OE(port_d_oe),
		.I_TIMER0_EVT(evt), .I_TIMER1_EVT(evt), .I_TIMER2_EVT(evt), .I_PIN_CHANGE_EVT(evt),
		.I_EXT_IRQ_EVT(evt), .I_SPI_STATUS_EVT(evt), .I_COMPARATOR_EVT(evt),
		.I_RESET_CAUSE_EVT(evt), .O_EXT_IRQ_MASK(), .O_NVM_CONTROL(), .O_NVM_DATA(),
		.O_NVM_ADDR(), .O_TIMER_PRESCALER(), .O_TIMER0_CONTROL_A(), .O_TIMER0_CONTROL_B(),
		.O_TIMER0_COUNT(), .O_TIMER0_COMPARE_A(), .O_TIMER0_COMPARE_B(), .O_SPI_CONTROL(),
		.O_SPI_DATA(), .O_SLEEP_CONTROL()
	);
	core_access_model i_core_access_model (
		.i_clk(mclk), .o_acc(acc), .i_rdata(rdata_q), .i_bit_true(bit_q)
	);
	// ********
	// Tasks
	// ********
	task automatic test_done();
		$display("checks %0d, mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
			errors++;
		end
	endtask
	task automatic op(input io_space_pkg::access_kind_t k, input logic ds,
		input logic [7:0] a, input logic [7:0] d, input logic [2:0] b);
		i_core_access_model.access(k, ds, a, d, b, rdata, bit_true);
	endtask
	task automatic wr(input logic ds, input logic [7:0] a, input logic [7:0] d);
		op(io_space_pkg::ACC_WRITE, ds, a, d, 3'h0);
	endtask
	task automatic rd(input logic ds, input logic [7:0] a, input logic [7:0] exp);
		op(io_space_pkg::ACC_READ, ds, a, 8'h00, 3'h0);
		chk($sformatf("read %h", a), exp, rdata);
	endtask
	// Event pulses reach every flag register at once
	task automatic pulse();
		@(negedge mclk);
		evt = 8'h03;
		@(negedge mclk);
		evt = 8'h00;
	endtask
	// ********
	// Clock, timeout and tests
	// ********
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			test_done();
		end
	end
	initial begin
		rstn = 1'b0;
		pins = 8'ha5;
		evt = 8'h00;
		repeat (12) @(posedge mclk);
		@(negedge mclk);
		rstn = 1'b1;
		rd(1'b0, 8'h0b, 8'h00);
		wr(1'b0, 8'h0b, 8'h5a);
		rd(1'b1, 8'h2b, 8'h5a);
		wr(1'b1, 8'h2a, 8'hc3);
		chk("port d oe", 8'hc3, port_d_oe);
		rd(1'b0, 8'h09, 8'ha5);
		op(io_space_pkg::ACC_TEST, 1'b0, 8'h0b, 8'h00, 3'h1);
		chk("bit 1", 8'h01, {7'h00, bit_true});
		op(io_space_pkg::ACC_TEST, 1'b0, 8'h0b, 8'h00, 3'h0);
		chk("bit 0", 8'h00, {7'h00, bit_true});
		$display("test port_d done");
		op(io_space_pkg::ACC_SETBIT, 1'b0, 8'h0b, 8'h00, 3'h0);
		rd(1'b0, 8'h0b, 8'h5b);
		op(io_space_pkg::ACC_CLRBIT, 1'b0, 8'h0b, 8'h00, 3'h6);
		rd(1'b0, 8'h0b, 8'h1b);
		wr(1'b0, 8'h2c, 8'h00);
		op(io_space_pkg::ACC_SETBIT, 1'b0, 8'h2c, 8'h00, 3'h2);
		rd(1'b0, 8'h2c, 8'h00);
		$display("test bit_ops done");
		rd(1'b0, 8'h4b, 8'h00);
		rd(1'b1, 8'h0b, 8'h00);
		rd(1'b1, 8'h6b, 8'h00);
		chk("ext sel", 8'h01, {7'h00, ext_sel});
		rd(1'b0, 8'h0c, 8'h00);
		rd(1'b0, 8'h06, 8'h25);
		i_core_access_model.lax = 1'b1;
		wr(1'b0, 8'h08, 8'hff);
		rd(1'b0, 8'h08, 8'h7f);
		chk("port c out", 8'h7f, port_c_out);
		wr(1'b0, 8'h33, 8'hff);
		rd(1'b0, 8'h33, 8'h0f);
		$display("test reach done");
		pulse();
		rd(1'b0, 8'h1c, 8'h03);
		rd(1'b0, 8'h34, 8'h03);
		wr(1'b0, 8'h34, 8'h01);
		rd(1'b0, 8'h34, 8'h01);
		wr(1'b0, 8'h1c, 8'h01);
		rd(1'b0, 8'h1c, 8'h02);
		wr(1'b0, 8'h1c, 8'h00);
		rd(1'b0, 8'h1c, 8'h02);
		pulse();
		op(io_space_pkg::ACC_SETBIT, 1'b0, 8'h1c, 8'h00, 3'h0);
		rd(1'b0, 8'h1c, 8'h02);
		op(io_space_pkg::ACC_CLRBIT, 1'b0, 8'h1c, 8'h00, 3'h1);
		rd(1'b0, 8'h1c, 8'h02);
		$display("test flags done");
		test_done();
	end
endmodule
`default_nettype wire
